// file: hdl/gpio_pkg.sv
// Shared constants for the two general-purpose ports.
// Assumes an 8-bit processor-side register port with 16-bit addresses.
package gpio_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 16;
  localparam logic [15:0] ADDR_PORT_DATA = 16'h8000;
  localparam logic [15:0] ADDR_DIRECTION = 16'h8001;
  localparam logic [15:0] ADDR_ANALOG_DATA = 16'h800a;
  localparam logic [15:0] ADDR_OPTIONS = 16'h8039;
  localparam int POWER_UP_POS = 7;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : gpio_pkg

// file: hdl/sync_if.sv
// Carrier between the port top and its pin synchroniser.
// Assumes the raw side arrives from pins outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport syncer (input raw, output synced);
  modport user (output raw, input synced);
endinterface : sync_if
`default_nettype wire

// file: hdl/pin_sync.sv
// Two-flop synchroniser for a group of input pins.
// Assumes clk and nrst of the port block; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw pins in, synchronised levels out
  sync_if.syncer sif
);
  logic [$bits(sif.raw)-1:0] meta_reg;
  logic [$bits(sif.raw)-1:0] stable_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg <= sif.raw;
      stable_reg <= meta_reg;
    end
  end

  assign sif.synced = stable_reg;
endmodule // pin_sync
`default_nettype wire

// file: hdl/gpio_ports.sv
// Bidirectional 8-bit port with per-bit direction, plus an 8-bit input-only
// port that the on-chip converter can claim. Registers sit on a simple
// processor strobe port: one access per strobe, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports #(
  parameter int WIDTH = gpio_pkg::PORT_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Processor register port
  input wire logic [gpio_pkg::ADDR_WIDTH-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [WIDTH-1:0] rdata,
  output logic rvalid,
  // Bidirectional port pins
  input wire logic [WIDTH-1:0] port_pin_in,
  output logic [WIDTH-1:0] port_pin_out,
  output logic [WIDTH-1:0] port_pin_oe,
  // Input-only port pins and converter control
  input wire logic [WIDTH-1:0] analog_shared_input_pins,
  output logic converter_power_up_bit
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  sync_if #(.WIDTH(2 * WIDTH)) pins ();
  assign pins.raw = {analog_shared_input_pins, port_pin_in};

  pin_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .sif(pins)
  );

  wire logic [WIDTH-1:0] port_level = pins.synced[WIDTH-1:0];
  wire logic [WIDTH-1:0] analog_level = pins.synced[2*WIDTH-1:WIDTH];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  // Unmapped addresses select nothing, so writes there drop and reads give zero.
  wire logic sel_data = (addr == gpio_pkg::ADDR_PORT_DATA);
  wire logic sel_dir = (addr == gpio_pkg::ADDR_DIRECTION);
  wire logic sel_analog = (addr == gpio_pkg::ADDR_ANALOG_DATA);
  wire logic sel_opt = (addr == gpio_pkg::ADDR_OPTIONS);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [WIDTH-1:0] timer_pin_port_data_reg;
  logic [WIDTH-1:0] pin_direction_control_reg;
  logic [WIDTH-1:0] options_reg;
  logic [WIDTH-1:0] rdata_reg;
  logic rvalid_reg;
  logic [WIDTH-1:0] rdata_next;

  // The data latch is written regardless of direction, so software can preset
  // a level before turning a bit into an output without a glitch.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_pin_port_data_reg <= gpio_pkg::DATA_RESET;
    end else if (wr && sel_data) begin
      timer_pin_port_data_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_direction_control_reg <= gpio_pkg::DIRECTION_RESET;
    end else if (wr && sel_dir) begin
      pin_direction_control_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      options_reg <= gpio_pkg::OPTIONS_RESET;
    end else if (wr && sel_opt) begin
      options_reg <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: each bit stands alone.
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      assign port_pin_oe[b] = pin_direction_control_reg[b];
      assign port_pin_out[b] = timer_pin_port_data_reg[b];
    end
  endgenerate

  // The input-only port has no drive path at all.
  assign converter_power_up_bit = options_reg[gpio_pkg::POWER_UP_POS];

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Output bits read back the latch; input bits read the pin.
  wire logic [WIDTH-1:0] port_read =
    (pin_direction_control_reg & timer_pin_port_data_reg) |
    (~pin_direction_control_reg & port_level);

  // Digital levels still read while the converter owns the pins; the value
  // is then only meaningful as a rough logic level.
  always_comb begin
    rdata_next = gpio_pkg::READ_ZERO;
    if (sel_data) begin
      rdata_next = port_read;
    end else if (sel_dir) begin
      rdata_next = pin_direction_control_reg;
    end else if (sel_analog) begin
      rdata_next = analog_level;
    end else if (sel_opt) begin
      rdata_next = options_reg;
    end
  end

  // A read answers one cycle after its strobe; rdata holds until the next read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= gpio_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd;
      if (rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Named steps that the multi-cycle properties below are built from.
  sequence s_dir_write(int unsigned bitn);
    wr && sel_dir && wdata[bitn];
  endsequence

  sequence s_opt_write;
    wr && sel_opt;
  endsequence

  sequence s_opt_quiet;
    !(wr && sel_opt);
  endsequence

  // Bit 0 is preset while it is still an input.
  sequence s_preset_bit0;
    wr && sel_data && !port_pin_oe[0];
  endsequence

  sequence s_data_quiet;
    !(wr && sel_data);
  endsequence

  a_dir_sets_oe: assert property (@(posedge clk) disable iff (!nrst)
    (wr && sel_dir) |=> (port_pin_oe == $past(wdata)))
    else $error("Direction write did not reach output enables.");

  a_out_follows_data: assert property (@(posedge clk) disable iff (!nrst)
    (port_pin_oe[0] && wr && sel_data) |=> port_pin_out[0] == $past(wdata[0]))
    else $error("Output pin did not follow written data.");

  a_input_reads_pin: assert property (@(posedge clk) disable iff (!nrst)
    (rd && sel_data && !wr) |=>
      ((rdata & ~$past(pin_direction_control_reg)) ==
       ($past(port_level) & ~$past(pin_direction_control_reg))))
    else $error("Input bit read did not return pin level.");

  a_bit_independent: assert property (@(posedge clk) disable iff (!nrst)
    (wr && sel_dir && wdata == 8'h80) |=> (port_pin_oe == 8'h80))
    else $error("Single-bit direction write affected other bits.");

  a_analog_reads: assert property (@(posedge clk) disable iff (!nrst)
    (rd && sel_analog) |=> rvalid && (rdata == $past(analog_level)))
    else $error("Input-only port read wrong value.");

  a_reset_digital: assert property (@(posedge clk)
    $rose(nrst) |-> !converter_power_up_bit)
    else $error("Converter powered after reset.");

  // The power-up bit must take the written level and keep it while no
  // further options write follows; a later write is free to change it.
  a_power_toggle: assert property (@(posedge clk) disable iff (!nrst)
    s_opt_write ##1 s_opt_quiet |->
      (converter_power_up_bit == $past(wdata[gpio_pkg::POWER_UP_POS])) ##1
      (converter_power_up_bit == $past(wdata[gpio_pkg::POWER_UP_POS], 2)))
    else $error("Power-up bit did not follow options write.");

  a_reset_inputs: assert property (@(posedge clk)
    $rose(nrst) |-> (port_pin_oe == gpio_pkg::DIRECTION_RESET))
    else $error("Port not all inputs after reset.");

  // A value preset while the bit is an input must be the one driven as
  // soon as the direction write turns that bit into an output.
  a_latch_kept: assert property (@(posedge clk) disable iff (!nrst)
    s_preset_bit0 ##1 s_data_quiet ##1 s_dir_write(0) |=>
      port_pin_oe[0] && (port_pin_out[0] == $past(wdata[0], 3)))
    else $error("Preset data not driven when bit became output.");

  // Writes aimed at the input-only port must leave every drive path alone.
  a_analog_read_only: assert property (@(posedge clk) disable iff (!nrst)
    (wr && sel_analog) |=>
      (port_pin_oe == $past(port_pin_oe)) && (port_pin_out == $past(port_pin_out)) &&
      (converter_power_up_bit == $past(converter_power_up_bit)))
    else $error("Write to the input-only port changed a drive register.");

  // Enables may only move on a direction write, one bit or many.
  a_dir_held: assert property (@(posedge clk) disable iff (!nrst)
    !(wr && sel_dir) |=> (port_pin_oe == $past(port_pin_oe)))
    else $error("Output enables changed without a direction write.");
endmodule // gpio_ports
`default_nettype wire

// file: tb/cpu_model.sv
// Processor-side model that issues register writes and reads on the strobe port.
// Assumes tb_top holds the queue exp_q that receives each expected read value.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock
  input wire logic clk,
  // Register strobe port
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Afterwards the address is inverted, so a late sample of the address cannot
  // look correct.
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic get(input logic [15:0] a, input logic [7:0] e);
    tb_top.exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
  endtask
endmodule // cpu_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the two general-purpose ports.
// Assumes the register map and reset values of gpio_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, nrst, wr, rd, rvalid, conv;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, pin_out, pin_oe, ext, ana, w, d, e, a;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int seed = 79433;
  wire logic [7:0] pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  gpio_ports gpio_ports_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rvalid(rvalid), .port_pin_in(pin_in), .port_pin_out(pin_out),
    .port_pin_oe(pin_oe), .analog_shared_input_pins(ana), .converter_power_up_bit(conv));
  cpu_model cpu_model_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic close_out();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Read answers are taken mid-cycle, clear of the edge that launches them.
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected_read", 8'h00, 8'hff);
      end else begin
        chk("rdata", exp_q.pop_front(), rdata);
      end
    end
  end

  initial begin
    #200000;
    bad_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    a = 8'($random(seed));
    ana = a;
    ext = 8'h5a;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("oe", 8'h00, pin_oe);
    chk("power", 8'h00, {7'h00, conv});
    cpu_model_i.get(gpio_pkg::ADDR_DIRECTION, 8'h00);
    cpu_model_i.get(gpio_pkg::ADDR_PORT_DATA, 8'h5a);
    cpu_model_i.get(gpio_pkg::ADDR_ANALOG_DATA, a);
    for (int i = 0; i < 12; i++) begin
      w = 8'($random(seed));
      d = (i == 0) ? 8'h80 : 8'($random(seed));
      e = 8'($random(seed));
      cpu_model_i.put(gpio_pkg::ADDR_PORT_DATA, w);
      cpu_model_i.put(gpio_pkg::ADDR_DIRECTION, d);
      ext <= e;
      // Pin levels pass two synchroniser flops before a read can see them.
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("oe", d, pin_oe);
      chk("out", w, pin_out);
      cpu_model_i.get(gpio_pkg::ADDR_PORT_DATA, (w & d) | (e & ~d));
    end
    cpu_model_i.put(gpio_pkg::ADDR_OPTIONS, 8'h80);
    @(negedge clk);
    chk("power", 8'h01, {7'h00, conv});
    cpu_model_i.put(gpio_pkg::ADDR_ANALOG_DATA, ~a);
    @(negedge clk);
    chk("analog_oe", d, pin_oe);
    chk("analog_out", w, pin_out);
    cpu_model_i.get(gpio_pkg::ADDR_ANALOG_DATA, a);
    cpu_model_i.put(gpio_pkg::ADDR_OPTIONS, 8'h00);
    @(negedge clk);
    chk("power", 8'h00, {7'h00, conv});
    cpu_model_i.get(16'h8123, 8'h00);
    // Power the converter again so the mid-run reset has something to undo.
    cpu_model_i.put(gpio_pkg::ADDR_OPTIONS, 8'h80);
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("oe", 8'h00, pin_oe);
    chk("power", 8'h00, {7'h00, conv});
    chk("out", gpio_pkg::DATA_RESET, pin_out);
    cpu_model_i.get(gpio_pkg::ADDR_DIRECTION, 8'h00);
    for (int j = 0; j < 20 && exp_q.size() > 0; j++) begin
      @(posedge clk);
    end
    if (exp_q.size() > 0) begin
      bad_count++;
    end
    close_out();
  end
endmodule // tb_top
`default_nettype wire
